// ==== hw/servo_ctrl_pkg.sv ====
package servo_ctrl_pkg;

    localparam int DATA_W = 8;
    localparam int SET_W  = 16;
    localparam int ADC_W  = 12;
    localparam int POS_W  = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_MODE       = 8'h04;
    localparam logic [7:0] REG_STATUS     = 8'h08;
    localparam logic [7:0] REG_SPEED_SET  = 8'h0c;
    localparam logic [7:0] REG_CURR_SET   = 8'h10;
    localparam logic [7:0] REG_SPEED_LIM  = 8'h14;
    localparam logic [7:0] REG_SEQ_SEL    = 8'h18;
    localparam logic [7:0] REG_TARGET_POS = 8'h1c;
    localparam logic [7:0] REG_PROFILE    = 8'h20;
    localparam logic [7:0] REG_SPEED_OUT  = 8'h24;
    localparam logic [7:0] REG_CURR_OUT   = 8'h28;
    localparam logic [7:0] REG_IO_CFG     = 8'h2c;
    localparam logic [7:0] REG_INTERP_POS = 8'h30;

    // control register bits
    localparam int CTRL_SW_EN     = 0;
    localparam int CTRL_START     = 1;
    localparam int CTRL_ERR_RST   = 2;
    localparam int CTRL_PRIO      = 3;
    localparam int CTRL_MODE_CONF = 4;

    // status register bits
    localparam int ST_ERR       = 4;
    localparam int ST_SEQ_BUSY  = 5;
    localparam int ST_MODE_REJ  = 6;
    localparam int ST_HW_EN     = 7;
    localparam int ST_INTERP_OK = 8;

    localparam logic [31:0] SPEED_LIM_RST = 32'h0000_7fff;
    localparam logic [3:0]  SEQ_SEL_NONE  = 4'h0;

    typedef enum logic [2:0] {
        MODE_IF_SPEED,
        MODE_IF_CURRENT,
        MODE_HOMING,
        MODE_SEQ_POS,
        MODE_INTERP_POS,
        MODE_AN_SPEED,
        MODE_AN_CURRENT
    } op_mode_t;

    typedef enum logic [1:0] {
        DEV_SWITCHED_ON,
        DEV_OP_ENABLED,
        DEV_FAULT
    } dev_state_t;

endpackage

// ==== hw/servo_mode_state_control.sv ====
// Operation
// - power-up enters defined state, deterministic transitions
// - software run enable toggles switched-on/enabled
// - mode change refused while operation enabled
// - interface speed mode tracks commanded speed
// - interface current mode tracks commanded current
// - homing starts on start bit, auto-stops
// - sequential move starts on start toggle
// - device generates profile from target position
// - accept interpolated points in CAN variant
// - analog speed follows input under hardware enable
// - analog current follows input under hardware enable
// - analog source supplies speed/torque only
// - clamp speed set value to mechanical limit
// - stand-alone auto-enables on hardware enable
// - error reset by bus; button stand-alone only
// - reset leaves error only if cause gone
// - power-on reset clears errors after both supplies
// - first analog channel setpoint, second logging
// - dedicated and general digital io classes
// - hardware enable off cuts power stage immediately; here on the third clock edge after the pin falls, through the synchroniser
// - no motion without hardware enable
//
// Local design decisions: the address-and-strobe port and the register addresses.
module servo_mode_state_control #(
    parameter int CAN_VARIANT = 1,   // interpolated trajectory support
    parameter int GPIO_N      = 2    // general purpose io count
) (
    input  wire logic                               mclk,            // system clock
    input  wire logic                               sys_rst,         // async reset
    input  wire logic [7:0]                         reg_addr,        // register address
    input  wire logic [31:0]                        reg_wdata,       // write data
    input  wire logic                               reg_wr,          // write strobe
    input  wire logic                               reg_rd,          // read strobe
    output logic      [31:0]                        reg_rdata,       // read data
    input  wire logic                               hw_enable_in,    // hardware enable pin
    input  wire logic                               panel_reset_in,  // front button
    input  wire logic                               aux_supply_ok,   // auxiliary supply good
    input  wire logic                               main_supply_ok,  // main supply good
    input  wire logic                               fault_cause,     // error cause active
    input  wire logic                               seq_done,        // sequence ended
    input  wire logic                               limit_pos_in,    // dedicated limit +
    input  wire logic                               limit_neg_in,    // dedicated limit -
    input  wire logic                               home_sw_in,      // dedicated homing switch
    input  wire logic                               stop_in,         // dedicated stop
    input  wire logic [GPIO_N-1:0]                  gpio_in,         // general inputs
    output logic      [GPIO_N-1:0]                  gpio_out,        // general outputs
    input  wire logic [servo_ctrl_pkg::ADC_W-1:0]   analog_setpoint_in, // channel 1
    input  wire logic [servo_ctrl_pkg::ADC_W-1:0]   analog_aux_in,   // channel 2, logging
    output logic                                    power_stage_en,  // power stage on
    output logic      [servo_ctrl_pkg::SET_W-1:0]   speed_cmd,       // clamped speed set
    output logic      [servo_ctrl_pkg::SET_W-1:0]   current_cmd,     // current set
    output logic      [servo_ctrl_pkg::POS_W-1:0]   target_pos,      // target or interp point
    output logic                                    seq_start,       // sequence start pulse
    output logic                                    homing_active,   // homing running
    output logic      [servo_ctrl_pkg::ADC_W-1:0]   log_sample       // logged aux channel
);

    localparam int SW = servo_ctrl_pkg::SET_W;
    localparam int AW = servo_ctrl_pkg::ADC_W;

    // signed clamp to symmetric limit
    function automatic logic [SW-1:0] clamp_speed(input logic [SW-1:0] v,
                                                  input logic [SW-1:0] lim);
        logic signed [SW-1:0] s;
        logic signed [SW-1:0] l;
        s = v;
        l = lim;
        if (s > l)
            clamp_speed = l;
        else if (s < -l)
            clamp_speed = SW'(-l);
        else
            clamp_speed = v;
    endfunction

    // sign-extend 12-bit converter word to set width
    function automatic logic [SW-1:0] widen_adc(input logic [AW-1:0] a);
        widen_adc = {{(SW-AW){a[AW-1]}}, a};
    endfunction

    // two-flop synchronisers for pin inputs
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [GPIO_N-1:0] gpio_s1_q;
    logic [GPIO_N-1:0] gpio_s2_q;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1_q  <= 8'h00;
            pin_s2_q  <= 8'h00;
            gpio_s1_q <= '0;
            gpio_s2_q <= '0;
        end
        else
        begin
            pin_s1_q  <= {seq_done, fault_cause, main_supply_ok, aux_supply_ok,
                          panel_reset_in, hw_enable_in, stop_in, home_sw_in};
            pin_s2_q  <= pin_s1_q;
            gpio_s1_q <= gpio_in;
            gpio_s2_q <= gpio_s1_q;
        end
    end
    logic hw_en;
    logic panel_rst;
    logic aux_ok;
    logic main_ok;
    logic cause;
    logic done;
    logic stop_ok;
    logic home_sw;
    assign {done, cause, main_ok, aux_ok, panel_rst, hw_en, stop_ok, home_sw} = pin_s2_q;

    logic [1:0] lim_s1_q;
    logic [1:0] lim_s2_q;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lim_s1_q <= 2'h0;
            lim_s2_q <= 2'h0;
        end
        else
        begin
            lim_s1_q <= {limit_pos_in, limit_neg_in};
            lim_s2_q <= lim_s1_q;
        end
    end

    // registers
    logic                           sw_en_q;
    logic                           start_q;
    logic                           prio_remote_master;
    logic                           mode_confirm_q;
    servo_ctrl_pkg::op_mode_t       mode_q;
    servo_ctrl_pkg::op_mode_t       mode_pend_q;
    logic                           mode_rej_q;
    logic [SW-1:0]                  speed_set_q;
    logic [SW-1:0]                  curr_set_q;
    logic [SW-1:0]                  speed_lim_q;
    logic [3:0]                     seq_sel_q;
    logic [servo_ctrl_pkg::POS_W-1:0] target_q;
    logic [31:0]                    profile_q;
    logic [GPIO_N-1:0]              gpio_cfg_q;
    logic                           interp_ok_q;
    servo_ctrl_pkg::dev_state_t     state_q;
    servo_ctrl_pkg::dev_state_t     state_d;
    logic                           bus_err_rst;

    wire wr_ctrl = reg_wr && reg_addr == servo_ctrl_pkg::REG_CTRL;
    wire op_en   = state_q == servo_ctrl_pkg::DEV_OP_ENABLED;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sw_en_q            <= 1'b0;
            prio_remote_master <= 1'b0;
            bus_err_rst        <= 1'b0;
            mode_confirm_q     <= 1'b0;
        end
        else
        begin
            bus_err_rst    <= wr_ctrl && reg_wdata[servo_ctrl_pkg::CTRL_ERR_RST];
            mode_confirm_q <= wr_ctrl && reg_wdata[servo_ctrl_pkg::CTRL_MODE_CONF];
            if (wr_ctrl)
            begin
                sw_en_q            <= reg_wdata[servo_ctrl_pkg::CTRL_SW_EN];
                prio_remote_master <= reg_wdata[servo_ctrl_pkg::CTRL_PRIO];
            end
        end
    end

    // start bit is level-held; homing uses its rise, sequences any change
    logic start_prev_q;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            start_q      <= 1'b0;
            start_prev_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                start_q <= reg_wdata[servo_ctrl_pkg::CTRL_START];
            start_prev_q <= start_q;
        end
    end

    // write then confirm applies the pending mode
    // writes while enabled are dropped and flagged
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q      <= servo_ctrl_pkg::MODE_IF_SPEED;
            mode_pend_q <= servo_ctrl_pkg::MODE_IF_SPEED;
            mode_rej_q  <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == servo_ctrl_pkg::REG_MODE)
            begin
                if (op_en)
                    mode_rej_q <= 1'b1;
                else if (reg_wdata[2:0] <= 3'(servo_ctrl_pkg::MODE_AN_CURRENT))
                    mode_pend_q <= servo_ctrl_pkg::op_mode_t'(reg_wdata[2:0]);
            end
            if (mode_confirm_q)
            begin
                if (op_en)
                    mode_rej_q <= 1'b1;
                else
                begin
                    mode_q     <= mode_pend_q;
                    mode_rej_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            speed_set_q <= '0;
            curr_set_q  <= '0;
            speed_lim_q <= servo_ctrl_pkg::SPEED_LIM_RST[SW-1:0];
            seq_sel_q   <= servo_ctrl_pkg::SEQ_SEL_NONE;
            target_q    <= '0;
            profile_q   <= '0;
            gpio_cfg_q  <= '0;
            interp_ok_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                servo_ctrl_pkg::REG_SPEED_SET:  speed_set_q <= reg_wdata[SW-1:0];
                servo_ctrl_pkg::REG_CURR_SET:   curr_set_q  <= reg_wdata[SW-1:0];
                servo_ctrl_pkg::REG_SPEED_LIM:  speed_lim_q <= reg_wdata[SW-1:0];
                servo_ctrl_pkg::REG_SEQ_SEL:    seq_sel_q   <= reg_wdata[3:0];
                servo_ctrl_pkg::REG_TARGET_POS: target_q    <= reg_wdata;
                servo_ctrl_pkg::REG_PROFILE:    profile_q   <= reg_wdata;
                servo_ctrl_pkg::REG_IO_CFG:     gpio_cfg_q  <= reg_wdata[GPIO_N-1:0];
                // interpolated points accepted only on the CAN build
                servo_ctrl_pkg::REG_INTERP_POS:
                begin
                    if (CAN_VARIANT != 0 && mode_q == servo_ctrl_pkg::MODE_INTERP_POS)
                    begin
                        target_q    <= reg_wdata;
                        interp_ok_q <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // supplies must both drop before a later reset can clear
    logic both_cycled_q;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            both_cycled_q <= 1'b0;
        else if (!main_ok && !aux_ok)
            both_cycled_q <= 1'b1;
        else if (state_q != servo_ctrl_pkg::DEV_FAULT)
            both_cycled_q <= 1'b0;
    end

    wire err_rst_req = bus_err_rst || (panel_rst && !prio_remote_master) ||
                       (both_cycled_q && main_ok && aux_ok);

    // single defined state after reset, every event mapped
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            servo_ctrl_pkg::DEV_SWITCHED_ON:
            begin
                if (cause)
                    state_d = servo_ctrl_pkg::DEV_FAULT;
                // stand-alone jumps in on hardware enable
                else if (hw_en && !prio_remote_master)
                    state_d = servo_ctrl_pkg::DEV_OP_ENABLED;
                // run enable; still needs hardware enable
                else if (hw_en && sw_en_q)
                    state_d = servo_ctrl_pkg::DEV_OP_ENABLED;
            end
            servo_ctrl_pkg::DEV_OP_ENABLED:
            begin
                if (cause)
                    state_d = servo_ctrl_pkg::DEV_FAULT;
                // hardware enable off drops out at once
                else if (!hw_en)
                    state_d = servo_ctrl_pkg::DEV_SWITCHED_ON;
                // run enable drop leaves enabled state under remote master priority only
                else if (prio_remote_master && !sw_en_q)
                    state_d = servo_ctrl_pkg::DEV_SWITCHED_ON;
            end
            servo_ctrl_pkg::DEV_FAULT:
            begin
                // reset only succeeds with cause cleared
                if (err_rst_req && !cause)
                    state_d = servo_ctrl_pkg::DEV_SWITCHED_ON;
            end
            default: state_d = servo_ctrl_pkg::DEV_FAULT;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            state_q <= servo_ctrl_pkg::DEV_SWITCHED_ON;
        else
            state_q <= state_d;
    end

    wire is_pos_mode = mode_q == servo_ctrl_pkg::MODE_HOMING ||
                       mode_q == servo_ctrl_pkg::MODE_SEQ_POS;
    wire seq_chosen  = seq_sel_q != servo_ctrl_pkg::SEQ_SEL_NONE;
    wire start_rise  = start_q && !start_prev_q;
    wire start_tog   = start_q != start_prev_q;

    // homing on start rise; sequence on any toggle
    // profile itself built downstream from target and profile word
    logic seq_busy_q;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            seq_start     <= 1'b0;
            seq_busy_q    <= 1'b0;
            homing_active <= 1'b0;
        end
        else
        begin
            seq_start <= 1'b0;
            if (!op_en || state_d != servo_ctrl_pkg::DEV_OP_ENABLED || done || !stop_ok)
            begin
                seq_busy_q    <= 1'b0;
                homing_active <= 1'b0;
            end
            else if (is_pos_mode && seq_chosen && !seq_busy_q &&
                     (mode_q == servo_ctrl_pkg::MODE_HOMING ? start_rise : start_tog))
            begin
                seq_start     <= 1'b1;
                seq_busy_q    <= 1'b1;
                homing_active <= mode_q == servo_ctrl_pkg::MODE_HOMING;
            end
        end
    end

    // set value selection
    // analog feeds speed and current only, never position
    // channel 1 is the setpoint source
    logic [SW-1:0] spd_src;
    logic [SW-1:0] cur_src;
    always_comb
    begin
        spd_src = '0;
        cur_src = '0;
        unique case (mode_q)
            servo_ctrl_pkg::MODE_IF_SPEED:   spd_src = speed_set_q;
            servo_ctrl_pkg::MODE_IF_CURRENT: cur_src = curr_set_q;
            servo_ctrl_pkg::MODE_AN_SPEED:   spd_src = widen_adc(analog_setpoint_in);
            servo_ctrl_pkg::MODE_AN_CURRENT: cur_src = widen_adc(analog_setpoint_in);
            servo_ctrl_pkg::MODE_HOMING,
            servo_ctrl_pkg::MODE_SEQ_POS,
            servo_ctrl_pkg::MODE_INTERP_POS: spd_src = profile_q[SW-1:0];
        endcase
    end

    // stop input zeroes demand; limits block motion in the locked sign
    wire spd_neg  = spd_src[SW-1];
    wire lim_lock = (spd_neg ? !lim_s2_q[0] : !lim_s2_q[1]) && spd_src != '0;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_stage_en <= 1'b0;
            speed_cmd      <= '0;
            current_cmd    <= '0;
            target_pos     <= '0;
            log_sample     <= '0;
        end
        else
        begin
            // stage follows enabled state, which tracks hw enable
            power_stage_en <= state_d == servo_ctrl_pkg::DEV_OP_ENABLED;
            speed_cmd   <= (op_en && stop_ok && !lim_lock) ?
                           clamp_speed(spd_src, speed_lim_q) : '0;
            current_cmd <= (op_en && stop_ok) ? cur_src : '0;
            target_pos  <= target_q;
            log_sample  <= analog_aux_in;
        end
    end

    // general io configured by software; dedicated ones fixed
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            gpio_out <= '0;
        else
            gpio_out <= gpio_cfg_q & gpio_s2_q;
    end

    // read path, data one cycle after strobe
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                servo_ctrl_pkg::REG_CTRL:
                    reg_rdata <= 32'({mode_confirm_q, prio_remote_master, 1'b0,
                                      start_q, sw_en_q});
                servo_ctrl_pkg::REG_MODE:      reg_rdata <= 32'(mode_q);
                servo_ctrl_pkg::REG_STATUS:
                    reg_rdata <= 32'({interp_ok_q, hw_en, mode_rej_q, seq_busy_q,
                                      state_q == servo_ctrl_pkg::DEV_FAULT,
                                      home_sw, 1'b0, state_q});
                servo_ctrl_pkg::REG_SPEED_SET:  reg_rdata <= 32'(speed_set_q);
                servo_ctrl_pkg::REG_CURR_SET:   reg_rdata <= 32'(curr_set_q);
                servo_ctrl_pkg::REG_SPEED_LIM:  reg_rdata <= 32'(speed_lim_q);
                servo_ctrl_pkg::REG_SEQ_SEL:    reg_rdata <= 32'(seq_sel_q);
                servo_ctrl_pkg::REG_TARGET_POS: reg_rdata <= target_q;
                servo_ctrl_pkg::REG_PROFILE:    reg_rdata <= profile_q;
                servo_ctrl_pkg::REG_SPEED_OUT:  reg_rdata <= 32'(speed_cmd);
                servo_ctrl_pkg::REG_CURR_OUT:   reg_rdata <= 32'(current_cmd);
                servo_ctrl_pkg::REG_IO_CFG:     reg_rdata <= 32'(gpio_cfg_q);
                default:                        reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule

// ==== verif/fieldbus_master_model.sv ====
module fieldbus_master_model (
    input  wire logic        mclk,      // system clock
    output logic      [7:0]  reg_addr,  // address
    output logic      [31:0] reg_wdata, // write data
    output logic             reg_wr,    // write strobe
    output logic             reg_rd     // read strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        // released lines flip so stale values never pass for valid ones
        reg_addr <= ~a;
        reg_wdata <= ~d;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask
endmodule

// ==== verif/servo_ctrl_properties.sv ====
module servo_ctrl_checker (
    input wire logic        mclk,           // clock
    input wire logic        sys_rst,        // reset
    input wire logic        reg_rd,         // read strobe
    input wire logic [31:0] reg_rdata,      // read data
    input wire logic        hw_enable_in,   // hw enable
    input wire logic        stop_in,        // stop pin
    input wire logic        power_stage_en, // power on
    input wire logic [15:0] speed_cmd,      // speed demand
    input wire logic [15:0] current_cmd,    // current demand
    input wire logic        seq_start,      // start pulse
    input wire logic [11:0] analog_aux_in,  // channel 2
    input wire logic [11:0] log_sample,     // logged value
    input wire logic [1:0]  gpio_in,        // general in
    input wire logic [1:0]  gpio_out        // general out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
    a_hw_off_cut: assert property (
        !hw_enable_in [*4] |-> !power_stage_en) else $error("power on without enable");
    a_cmd_idle_zero: assert property (
        !power_stage_en && !$past(power_stage_en) |-> speed_cmd == 16'h0 && current_cmd == 16'h0)
        else $error("demand while disabled");
    a_start_one_cycle: assert property (
        seq_start |=> !seq_start) else $error("start pulse too long");
    a_start_powered: assert property (
        seq_start |-> power_stage_en) else $error("start while disabled");
    a_stop_zero: assert property (
        !stop_in [*4] |-> speed_cmd == 16'h0) else $error("speed despite stop");
    a_log_follow: assert property (
        !$past(sys_rst) |-> log_sample == $past(analog_aux_in)) else $error("log lags");
    a_enable_needs_hw: assert property (
        $rose(power_stage_en) |-> $past(hw_enable_in, 3)) else $error("enable without pin");
    a_gpio_gated: assert property (
        (gpio_out & ~$past(gpio_in, 3)) == 2'h0) else $error("output without input");

    cover property ($rose(power_stage_en));
    cover property ($fell(power_stage_en));
    cover property (seq_start);
endmodule

bind servo_mode_state_control servo_ctrl_checker i_servo_ctrl_checker (
    .mclk, .sys_rst, .reg_rd, .reg_rdata, .hw_enable_in, .stop_in, .power_stage_en,
    .speed_cmd, .current_cmd, .seq_start, .analog_aux_in, .log_sample, .gpio_in, .gpio_out
);

// ==== verif/tb_servo_mode_state_control.sv ====
module tb_servo_mode_state_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, sys_rst = 1'b1, one = 1'b1, rd_d = 1'b0;
    logic        hw_enable_in = 1'b0, panel_reset_in = 1'b0, fault_cause = 1'b0;
    logic        seq_done = 1'b0, stop_in = 1'b1, home_sw_in = 1'b0;
    logic        reg_wr, reg_rd, power_stage_en, seq_start, homing_active;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, target_pos;
    logic [1:0]  gpio_in = 2'h0;
    logic [11:0] analog_setpoint_in = 12'h0, analog_aux_in = 12'h0;
    logic [15:0] speed_cmd;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    int          n_errors = 0, checks_done = 0, n_start = 0;

    fieldbus_master_model i_fieldbus_master_model (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    servo_mode_state_control i_servo_mode_state_control (
        .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_enable_in,
        .panel_reset_in, .aux_supply_ok(one), .main_supply_ok(one), .fault_cause, .seq_done,
        .limit_pos_in(one), .limit_neg_in(one), .home_sw_in, .stop_in, .gpio_in, .gpio_out(),
        .analog_setpoint_in, .analog_aux_in, .power_stage_en, .speed_cmd, .current_cmd(),
        .target_pos, .seq_start, .homing_active, .log_sample()
    );

    always #20 mclk = ~mclk;

    task automatic results();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (!ok)
        begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_fieldbus_master_model.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({m, x});
        i_fieldbus_master_model.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wait_pwr(input logic v);
        int n;
        n = 0;
        while (power_stage_en !== v && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        chk(n < 20, "power stage wait");
        if (n >= 20)
            results();
    endtask

    initial
    begin
        void'($urandom(32'h2666da8e));
        forever
        begin
            @(posedge mclk);
            analog_aux_in <= 12'($urandom);
            analog_setpoint_in <= 12'($urandom);
            gpio_in <= 2'($urandom);
            n_start <= n_start + int'(seq_start === 1'b1);
            if (rd_d)
            begin
                e = exp_q.pop_front();
                chk((reg_rdata & e[63:32]) === e[31:0], "read data");
            end
            rd_d <= reg_rd;
        end
    end

    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        wr(servo_ctrl_pkg::REG_IO_CFG, 32'h3);
        rd(servo_ctrl_pkg::REG_STATUS, 32'h0, 32'hff);
        rd(servo_ctrl_pkg::REG_SPEED_LIM, servo_ctrl_pkg::SPEED_LIM_RST, '1);
        rd(8'hfc, 32'h0, '1);
        hw_enable_in <= 1'b1;
        wait_pwr(1'b1);
        wr(servo_ctrl_pkg::REG_MODE, 32'h1);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h10);
        rd(servo_ctrl_pkg::REG_STATUS, 32'hc1, 32'hc3);
        hw_enable_in <= 1'b0;
        wait_pwr(1'b0);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h8);
        hw_enable_in <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(power_stage_en === 1'b0, "remote master must wait");
        // zero demand before enabling
        wr(servo_ctrl_pkg::REG_SPEED_SET, 32'h0);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h9);
        wait_pwr(1'b1);
        wr(servo_ctrl_pkg::REG_SPEED_LIM, 32'h100);
        wr(servo_ctrl_pkg::REG_SPEED_SET, 32'h7000);
        repeat (3) @(posedge mclk);
        chk(speed_cmd === 16'h0100, "speed not clamped");
        wr(servo_ctrl_pkg::REG_SPEED_SET, 32'h0);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h8);
        wait_pwr(1'b0);
        wr(servo_ctrl_pkg::REG_MODE, 32'h3);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h18);
        wr(servo_ctrl_pkg::REG_SEQ_SEL, 32'h1);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h9);
        wait_pwr(1'b1);
        wr(servo_ctrl_pkg::REG_CTRL, 32'hb);
        repeat (3) @(posedge mclk);
        chk(n_start == 1, "sequence not started");
        rd(servo_ctrl_pkg::REG_STATUS, 32'h20, 32'h20);
        seq_done <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(servo_ctrl_pkg::REG_STATUS, 32'h0, 32'h20);
        seq_done <= 1'b0;
        fault_cause <= 1'b1;
        wait_pwr(1'b0);
        wr(servo_ctrl_pkg::REG_CTRL, 32'hc);
        rd(servo_ctrl_pkg::REG_STATUS, 32'h2, 32'h3);
        fault_cause <= 1'b0;
        stop_in <= 1'b0;
        panel_reset_in <= 1'b1;
        repeat (5) @(posedge mclk);
        panel_reset_in <= 1'b0;
        stop_in <= 1'b1;
        rd(servo_ctrl_pkg::REG_STATUS, 32'h2, 32'h3);
        wr(servo_ctrl_pkg::REG_CTRL, 32'hc);
        rd(servo_ctrl_pkg::REG_STATUS, 32'h0, 32'h3);
        wr(servo_ctrl_pkg::REG_MODE, 32'h2);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h18);
        wr(servo_ctrl_pkg::REG_TARGET_POS, 32'h1234_5678);
        wr(servo_ctrl_pkg::REG_CTRL, 32'h9);
        wait_pwr(1'b1);
        wr(servo_ctrl_pkg::REG_CTRL, 32'hb);
        repeat (2) @(posedge mclk);
        chk(homing_active === 1'b1 && n_start == 2, "homing");
        chk(target_pos === 32'h1234_5678, "target");
        repeat (3) @(posedge mclk);
        results();
    end
endmodule
